// *** param_write_pkg.sv ***
package param_write_pkg;
   // =====================================================================
   // frame layout and protocol codes
   localparam logic [7:0] FC_WRITE = 8'h06;
   localparam logic [7:0] EXC_BIT = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_DATA = 8'h03;
   localparam logic [3:0] REQ_LEN = 4'h8;
   localparam logic [3:0] MIN_LEN = 4'h4;
   localparam logic [3:0] ECHO_BODY = 4'h6;
   localparam logic [3:0] EXC_BODY = 4'h3;
   localparam logic [3:0] CNT_MAX = 4'hf;
   // =====================================================================
   // register map
   localparam logic [15:0] REG_MOTOR = 16'h2000;
   localparam logic [15:0] REG_BAUD = 16'h3000;
   localparam logic [15:0] REG_STATION = 16'h3010;
   localparam logic [15:0] REG_MODE = 16'h3020;
   localparam logic [15:0] MODE_MIN = 16'h0001;
   localparam logic [15:0] MODE_MAX = 16'h0004;
   localparam logic [15:0] MODE_SERIAL = 16'h0002;
   // =====================================================================
   // reset values
   localparam logic [15:0] BAUD_RST = 16'h0004;
   localparam logic [15:0] STATION_RST = 16'h0001;
   localparam logic [15:0] MODE_RST = 16'h0001;
   // =====================================================================
   // crc
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;

   function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
                                              input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc16_byte
endpackage : param_write_pkg

// *** crc16_unit.sv ***
`timescale 1ns/1ps
module crc16_unit (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [15:0] crc_q
);
   // =====================================================================
   // running crc, reflected polynomial, low byte goes out first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crc_q <= param_write_pkg::CRC_INIT;
      end else if (clear) begin
         crc_q <= param_write_pkg::CRC_INIT;
      end else if (en) begin
         crc_q <= param_write_pkg::crc16_byte(crc_q, data);
      end
   end
endmodule : crc16_unit

// *** serial_param_write_slave.sv ***
`timescale 1ns/1ps
module serial_param_write_slave (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_frame_end,
   input wire logic tx_ready,
   output logic tx_valid_q,
   output logic [7:0] tx_data_q,
   output logic [15:0] baud_sel_q,
   output logic [15:0] station_q,
   output logic [15:0] ctrl_mode_q,
   output logic serial_ctrl_q,
   output logic motor_cmd_valid_q,
   output logic [15:0] motor_cmd_q
);
   typedef enum logic [2:0] {
      st_rx, st_check, st_exec, st_tx, st_crc_lo, st_crc_hi
   } state_t;

   state_t state_q;
   state_t state_d;
   logic [7:0] buf_q [8];
   logic [3:0] cnt_q;
   logic [3:0] len_q;
   logic [3:0] idx_q;
   logic [15:0] crc_q;
   logic crc_clear;
   logic crc_en;
   logic [7:0] crc_data;
   logic [15:0] reg_addr;
   logic [15:0] reg_val;
   logic [7:0] exc;
   logic frame_ok;
   logic tx_hs;
   logic [15:0] baud_pend_q;
   logic baud_pend_flag_q;

   assign reg_addr = {buf_q[2], buf_q[3]};
   assign reg_val = {buf_q[4], buf_q[5]};
   assign tx_hs = tx_valid_q && tx_ready;

   // =====================================================================
   // crc shared by rx and tx; reseeded after each check and each reply
   assign crc_clear = (state_q == st_check) ||
                      (state_q == st_crc_hi && tx_hs);
   assign crc_en = (state_q == st_rx && rx_valid) ||
                   (state_q == st_tx && tx_hs);
   assign crc_data = (state_q == st_rx) ? rx_data : tx_data_q;

   crc16_unit u_crc (
      .clk(clk),
      .rstn(rstn),
      .clear(crc_clear),
      .en(crc_en),
      .data(crc_data),
      .crc_q(crc_q)
   );

   // =====================================================================
   // frame acceptance
   // crc residue, length and station address check
   assign frame_ok = (crc_q == param_write_pkg::CRC_GOOD) &&
                     (cnt_q >= param_write_pkg::MIN_LEN) &&
                     (buf_q[0] == station_q[7:0]) &&
                     (buf_q[1] != param_write_pkg::FC_WRITE ||
                      cnt_q == param_write_pkg::REQ_LEN);

   // =====================================================================
   // request decode; address is judged before data
   always_comb begin
      exc = param_write_pkg::EXC_NONE;
      if (buf_q[1] != param_write_pkg::FC_WRITE) begin
         exc = param_write_pkg::EXC_FUNC;
      end else if (reg_addr != param_write_pkg::REG_BAUD &&
                   reg_addr != param_write_pkg::REG_STATION &&
                   reg_addr != param_write_pkg::REG_MODE &&
                   reg_addr != param_write_pkg::REG_MOTOR) begin
         exc = param_write_pkg::EXC_ADDR;
      end else if (reg_addr == param_write_pkg::REG_MODE &&
                   (reg_val < param_write_pkg::MODE_MIN ||
                    reg_val > param_write_pkg::MODE_MAX)) begin
         exc = param_write_pkg::EXC_DATA;
      end
   end

   // =====================================================================
   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         st_rx: begin
            if (rx_frame_end) begin
               state_d = st_check;
            end
         end
         st_check: begin
            state_d = frame_ok ? st_exec : st_rx;
         end
         st_exec: begin
            state_d = st_tx;
         end
         st_tx: begin
            if (tx_hs && idx_q == len_q - 4'h1) begin
               state_d = st_crc_lo;
            end
         end
         st_crc_lo: begin
            if (tx_hs) begin
               state_d = st_crc_hi;
            end
         end
         st_crc_hi: begin
            if (tx_hs) begin
               state_d = st_rx;
            end
         end
         default: begin
            state_d = st_rx;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= st_rx;
      end else begin
         state_q <= state_d;
      end
   end

   // =====================================================================
   // receive count; saturates so long frames still reach the crc check
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 4'h0;
      end else if (state_q == st_check) begin
         cnt_q <= 4'h0;
      end else if (state_q == st_rx && rx_valid && cnt_q != 4'hf) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // =====================================================================
   // frame buffer: request in, reply out
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
         len_q <= 4'h0;
      end else if (state_q == st_rx && rx_valid &&
                   cnt_q < param_write_pkg::REQ_LEN) begin
         buf_q[cnt_q[2:0]] <= rx_data;
      end else if (state_q == st_exec) begin
         if (exc != param_write_pkg::EXC_NONE) begin
            buf_q[1] <= buf_q[1] | param_write_pkg::EXC_BIT;
            buf_q[2] <= exc;
            len_q <= param_write_pkg::EXC_BODY;
         end else begin
            len_q <= param_write_pkg::ECHO_BODY;
            if (reg_addr == param_write_pkg::REG_STATION) begin
               buf_q[0] <= reg_val[7:0];
            end
         end
      end
   end

   // =====================================================================
   // parameter registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         station_q <= param_write_pkg::STATION_RST;
      end else if (state_q == st_exec && exc == param_write_pkg::EXC_NONE &&
                   reg_addr == param_write_pkg::REG_STATION) begin
         station_q <= reg_val;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_mode_q <= param_write_pkg::MODE_RST;
         serial_ctrl_q <= 1'b0;
      end else if (state_q == st_exec && exc == param_write_pkg::EXC_NONE &&
                   reg_addr == param_write_pkg::REG_MODE) begin
         ctrl_mode_q <= reg_val;
         serial_ctrl_q <= (reg_val == param_write_pkg::MODE_SERIAL);
      end
   end

   // the running reply keeps the old rate; switch once it has left
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         baud_sel_q <= param_write_pkg::BAUD_RST;
         baud_pend_q <= param_write_pkg::BAUD_RST;
         baud_pend_flag_q <= 1'b0;
      end else if (state_q == st_exec && exc == param_write_pkg::EXC_NONE &&
                   reg_addr == param_write_pkg::REG_BAUD) begin
         baud_pend_q <= reg_val;
         baud_pend_flag_q <= 1'b1;
      end else if (state_q == st_crc_hi && tx_hs && baud_pend_flag_q) begin
         baud_sel_q <= baud_pend_q;
         baud_pend_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         motor_cmd_valid_q <= 1'b0;
         motor_cmd_q <= 16'h0000;
      end else begin
         motor_cmd_valid_q <= state_q == st_exec &&
                              exc == param_write_pkg::EXC_NONE &&
                              reg_addr == param_write_pkg::REG_MOTOR &&
                              serial_ctrl_q;
         if (state_q == st_exec && reg_addr == param_write_pkg::REG_MOTOR &&
             exc == param_write_pkg::EXC_NONE && serial_ctrl_q) begin
            motor_cmd_q <= reg_val;
         end
      end
   end

   // =====================================================================
   // transmit: body bytes, then crc low byte, then crc high byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_valid_q <= 1'b0;
         tx_data_q <= 8'h00;
         idx_q <= 4'h0;
      end else begin
         case (state_q)
            st_tx: begin
               if (tx_hs) begin
                  tx_valid_q <= 1'b0;
                  idx_q <= idx_q + 4'h1;
               end else if (!tx_valid_q) begin
                  tx_data_q <= buf_q[idx_q[2:0]];
                  tx_valid_q <= 1'b1;
               end
            end
            st_crc_lo, st_crc_hi: begin
               if (tx_hs) begin
                  tx_valid_q <= 1'b0;
               end else if (!tx_valid_q) begin
                  tx_data_q <= (state_q == st_crc_lo) ? crc_q[7:0] :
                               crc_q[15:8];
                  tx_valid_q <= 1'b1;
               end
            end
            default: begin
               tx_valid_q <= 1'b0;
               idx_q <= 4'h0;
            end
         endcase
      end
   end

   // =====================================================================
   // checks
   // unsupported function
   func_exc_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_exec && buf_q[1] != param_write_pkg::FC_WRITE) |=>
      (buf_q[2] == param_write_pkg::EXC_FUNC &&
       len_q == param_write_pkg::EXC_BODY))
      else $error("unsupported function not refused with 01");
   exc_bit_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_exec && exc != param_write_pkg::EXC_NONE) |=>
      (buf_q[1] == ($past(buf_q[1]) | param_write_pkg::EXC_BIT)))
      else $error("exception function code lacks top bit");
   bad_addr_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_exec && buf_q[1] == param_write_pkg::FC_WRITE &&
       reg_addr == 16'h3040) |=> (buf_q[2] == param_write_pkg::EXC_ADDR))
      else $error("unopened address not refused with 02");
   mode_range_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctrl_mode_q >= param_write_pkg::MODE_MIN &&
       ctrl_mode_q <= param_write_pkg::MODE_MAX))
      else $error("control mode out of range");
   baud_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_tx || state_q == st_exec) |=> $stable(baud_sel_q))
      else $error("baud rate changed during a transfer");
   station_echo_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_exec && exc == param_write_pkg::EXC_NONE &&
       reg_addr == param_write_pkg::REG_STATION) |=>
      (buf_q[0] == station_q[7:0]))
      else $error("reply address is not the new station address");
   serial_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      serial_ctrl_q |-> (ctrl_mode_q == param_write_pkg::MODE_SERIAL))
      else $error("serial control flag disagrees with mode");
   motor_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      motor_cmd_valid_q |-> $past(serial_ctrl_q))
      else $error("motor command passed outside serial mode");
   echo_len_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_exec && exc == param_write_pkg::EXC_NONE) |=>
      (len_q == param_write_pkg::ECHO_BODY) ##1 tx_valid_q)
      else $error("valid write not echoed");
   crc_drop_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_check && crc_q != param_write_pkg::CRC_GOOD) |=>
      (state_q == st_rx && !tx_valid_q))
      else $error("frame with bad crc was answered");
   crc_start_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == st_rx && cnt_q == 4'h0) |->
      (crc_q == param_write_pkg::CRC_INIT))
      else $error("request crc does not start from its seed");
endmodule : serial_param_write_slave

// *** host_link_model.sv ***
`timescale 1ns/1ps
// =====================================================
// far side: host that sends request frames
module host_link_model (
   input wire logic clk,
   input wire logic slow,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_frame_end,
   output logic tx_ready
);
   logic [1:0] stall_q;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h5a;
      rx_frame_end = 1'b0;
      tx_ready = 1'b1;
      stall_q = 2'h0;
   end

   // slow host takes a reply byte only one cycle in three
   always @(negedge clk) begin
      stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
      tx_ready <= !slow || (stall_q == 2'h2);
   end

   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = b[i];
      end
      @(negedge clk);
      rx_valid = 1'b0;
      // released line shows the inverse, never the last byte
      rx_data = ~rx_data;
      rx_frame_end = 1'b1;
      @(negedge clk);
      rx_frame_end = 1'b0;
   endtask : send
endmodule : host_link_model

// *** tb_serial_param_write_slave.sv ***
`timescale 1ns/1ps
`define chk(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module tb_serial_param_write_slave;
   logic clk, rstn, rx_valid, rx_frame_end, tx_ready, slow;
   logic [7:0] rx_data, tx_data_q, stn;
   logic tx_valid_q, serial_ctrl_q, motor_cmd_valid_q;
   logic [15:0] baud_sel_q, station_q, ctrl_mode_q, motor_cmd_q, m;
   logic [7:0] exp_q[$];
   logic [31:0] seed, v;
   int miscompares, comparisons, pulses;

   serial_param_write_slave serial_param_write_slave_inst (.clk(clk),
      .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
      .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
      .baud_sel_q(baud_sel_q), .station_q(station_q),
      .ctrl_mode_q(ctrl_mode_q), .serial_ctrl_q(serial_ctrl_q),
      .motor_cmd_valid_q(motor_cmd_valid_q), .motor_cmd_q(motor_cmd_q));

   host_link_model host_link_model_inst (.clk(clk), .slow(slow),
      .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // =====================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction : crc_of

   // code 00 means echo; frames not for us or with bad crc get nothing
   task automatic wr(input logic [7:0] ad, fc, input logic [15:0] rg,
                     val, input logic [7:0] code, input bit bad);
      logic [7:0] rq[$];
      logic [7:0] rp[$];
      logic [15:0] c;
      rq = {ad, fc, rg[15:8], rg[7:0], val[15:8], val[7:0]};
      c = crc_of(rq);
      rq.push_back(c[7:0] ^ {7'h0, bad});
      rq.push_back(c[15:8]);
      if (!bad && ad == stn) begin
         rp = rq[0:5];
         // reply goes out under the new address
         if (code == 8'h00 && rg == 16'h3010) rp[0] = val[7:0];
         // exception reply flags the function code
         if (code != 8'h00) rp = {ad, fc | 8'h80, code};
         c = crc_of(rp);
         rp.push_back(c[7:0]);
         rp.push_back(c[15:8]);
         foreach (rp[i]) exp_q.push_back(rp[i]);
      end
      host_link_model_inst.send(rq);
   endtask : wr

   task automatic fin(input string name);
      int k;
      repeat (12) @(negedge clk);
      for (k = 0; k < 300 && exp_q.size() > 0; k++) begin
         @(negedge clk);
      end
      repeat (3) @(negedge clk);
      `chk(exp_q.size(), 0)
      $display("test %s done", name);
   endtask : fin

   task automatic close_out();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // =====================================================
   // output watcher
   always @(posedge clk) begin
      logic [7:0] e;
      if (rstn && tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
         // an unexpected byte is compared against its own inverse
         e = exp_q.size() > 0 ? exp_q.pop_front() : ~tx_data_q;
         `chk(tx_data_q, e)
      end
      if (motor_cmd_valid_q === 1'b1) pulses++;
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end

   // =====================================================
   // tests
   initial begin
      rstn = 1'b0;
      slow = 1'b0;
      seed = 32'h3f;
      stn = 8'h01;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      // new baud only after the reply
      wr(stn, 8'h06, 16'h3000, 16'h0003, 8'h00, 1'b0);
      for (int i = 0; i < 40 && tx_valid_q !== 1'b1; i++) @(negedge clk);
      `chk(baud_sel_q, 16'h0004)
      fin("baud");
      `chk(baud_sel_q, 16'h0003)
      slow = 1'b1;
      wr(stn, 8'h07, 16'h3020, 16'h0002, 8'h01, 1'b0);
      fin("fc07");
      wr(stn, 8'h10, 16'h3020, 16'h0002, 8'h01, 1'b0);
      fin("fc10");
      wr(stn, 8'h06, 16'h3040, 16'h0002, 8'h02, 1'b0);
      fin("addr");
      wr(stn, 8'h06, 16'h3020, 16'h0005, 8'h03, 1'b0);
      fin("val5");
      wr(stn, 8'h06, 16'h3020, 16'h0000, 8'h03, 1'b0);
      fin("val0");
      `chk(ctrl_mode_q, 16'h0001)
      slow = 1'b0;
      pulses = 0;
      // motor command ignored outside serial mode
      wr(stn, 8'h06, 16'h2000, 16'h0008, 8'h00, 1'b0);
      fin("motor off");
      `chk(pulses, 0)
      `chk(motor_cmd_q, 16'h0000)
      wr(stn, 8'h06, 16'h3020, 16'h0002, 8'h00, 1'b0);
      fin("serial");
      `chk(serial_ctrl_q, 1'b1)
      wr(stn, 8'h06, 16'h2000, 16'h0004, 8'h00, 1'b0);
      fin("motor on");
      `chk(pulses, 1)
      `chk(motor_cmd_q, 16'h0004)
      wr(stn, 8'h06, 16'h3020, 16'h0003, 8'h00, 1'b1);
      fin("crc");
      `chk(ctrl_mode_q, 16'h0002)
      // station change, old address then ignored
      wr(stn, 8'h06, 16'h3010, 16'h0014, 8'h00, 1'b0);
      fin("station");
      stn = 8'h14;
      `chk(station_q, 16'h0014)
      wr(8'h01, 8'h06, 16'h3020, 16'h0003, 8'h00, 1'b0);
      fin("old addr");
      for (int n = 0; n < 6; n++) begin
         v = xs();
         slow = v[8];
         m = {14'h0, v[1:0]} + 16'h0001;
         wr(stn, 8'h06, 16'h3020, m, 8'h00, 1'b0);
         fin("rand mode");
         `chk(ctrl_mode_q, m)
         `chk(serial_ctrl_q, m == 16'h0002)
         wr(stn, 8'h06, 16'h3000, v[31:16], 8'h00, 1'b0);
         fin("rand baud");
         `chk(baud_sel_q, v[31:16])
      end
      close_out();
   end
endmodule : tb_serial_param_write_slave
